// ---- rtl/lum_pkg.sv ----
/*
 * Shared constants for the luminaire frame data latch: clock-derived
 * timing counts, frame layout, Wishbone register map and reset values.
 * Assumes a 40 MHz system clock and a 32-bit Wishbone data bus.
 */
package lum_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ            = 40_000_000;
	localparam int INTERVAL_NS       = 1000;
	localparam int SYNC_QUAL_US      = 10;
	localparam int STANDBY_MS        = 500;
	localparam int SYNC_TIMEOUT_MS   = 220;
	localparam int INTERVAL_CYC      = (CLK_HZ / 1_000_000) * INTERVAL_NS / 1000;
	localparam int SYNC_QUAL_CYC     = (CLK_HZ / 1_000_000) * SYNC_QUAL_US;
	localparam int STANDBY_CYC       = (CLK_HZ / 1000) * STANDBY_MS;
	localparam int SYNC_TIMEOUT_CYC  = (CLK_HZ / 1000) * SYNC_TIMEOUT_MS;
	localparam int INTERVALS         = 10;

	// ----------------------------------------------------------------
	// Intervals within one bit field
	// ----------------------------------------------------------------
	localparam logic [3:0] IV_LATCH   = 4'h1;
	localparam logic [3:0] IV_COUNT   = 4'h2;
	localparam logic [3:0] IV_CLEAR   = 4'h3;
	localparam logic [3:0] IV_SAMP_A  = 4'h4;
	localparam logic [3:0] IV_SAMP_E  = 4'h8;
	localparam logic [3:0] IV_SHIFT   = 4'h9;

	// ----------------------------------------------------------------
	// Frame layout, in data bit counts
	// ----------------------------------------------------------------
	localparam logic [5:0] CNT_ADDR_SAMPLE = 6'h09;
	localparam logic [5:0] CNT_LAMP_FIRST  = 6'h0A;
	localparam logic [5:0] CNT_LAMP_LAST   = 6'h0D;
	localparam logic [5:0] CNT_SLOT_INT    = 6'h15;
	localparam logic [5:0] CNT_SLOT_LAMP   = 6'h16;
	localparam logic [5:0] CNT_SLOT_PAN    = 6'h1D;
	localparam logic [5:0] CNT_SLOT_TILT   = 6'h25;
	localparam logic [5:0] CNT_SLOT_COLOR  = 6'h2D;
	localparam logic [5:0] CNT_SLOT_BEAM   = 6'h35;
	localparam logic [5:0] CNT_FRAME_END   = 6'h39;

	// Lamp control latch bit positions.
	localparam int LC_IGNITE = 0;
	localparam int LC_FLASH  = 1;
	localparam int LC_CHASE  = 2;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_ADDR    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_LATCH0  = 4'h8;
	localparam logic [3:0] REG_LATCH1  = 4'hC;
	localparam logic [7:0] ADDR_RESET  = 8'h01;

	// Color byte bits [7:5] select a wheel position code per wheel.
	localparam logic [2:0] WHEEL_LUT [3][8] = '{
		'{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7},
		'{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6},
		'{3'h0, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1}
	};

endpackage

// ---- rtl/frame_timing_if.sv ----
/*
 * Bundle of bit-field timing strobes between the sampler and the core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface frame_timing_if;
	logic voted_bit;
	logic shift_strobe;
	logic latch_strobe;
	logic count_strobe;
	logic clear_strobe;
	logic sync_accept;
	logic frame_done;

	modport sampler (
		output voted_bit, shift_strobe, latch_strobe, count_strobe,
		output clear_strobe, sync_accept,
		input  frame_done
	);
	modport core (
		input  voted_bit, shift_strobe, latch_strobe, count_strobe,
		input  clear_strobe, sync_accept,
		output frame_done
	);
endinterface
`default_nettype wire

// ---- rtl/bit_sampler.sv ----
/*
 * Sync qualifier, 1 us interval timer and five-sample bit voter.
 * Assumes raw asynchronous sync and data pins; both are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_sampler (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sync_in_i,
	input  wire logic       serial_bit_in_i,
	frame_timing_if.sampler ft
);
	import lum_pkg::*;

	logic [1:0] sync_meta_ff;
	logic [1:0] data_meta_ff;
	logic [8:0] qual_ff;
	logic       armed_ff;
	logic       running_ff;
	logic       last_ff;
	logic [5:0] div_ff;
	logic [3:0] iv_ff;
	logic [4:0] samp_ff;
	logic       tick;
	logic       qual_hit;
	logic       sync_s;
	logic       data_s;

	assign sync_s   = sync_meta_ff[1];
	assign data_s   = data_meta_ff[1];
	assign tick     = running_ff && (div_ff == 6'(INTERVAL_CYC - 1));
	assign qual_hit = sync_s && armed_ff && (qual_ff == 9'(SYNC_QUAL_CYC - 1)); // [R18]

	function automatic logic vote5(input logic [4:0] s);
		logic [2:0] n;
		n = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]) + 3'(s[4]);
		return n >= 3'h3;
	endfunction

	always_ff @(posedge clk_i) begin
		sync_meta_ff <= {sync_meta_ff[0], sync_in_i};
		data_meta_ff <= {data_meta_ff[0], serial_bit_in_i};
	end

	// ------------------------------------------------------------
	// Sync qualifier
	// ------------------------------------------------------------
	// A short pulse drops the count back to zero and is ignored.
	always_ff @(posedge clk_i) begin
		if (rst_i || !sync_s) begin
			qual_ff  <= '0; // [R18]
			armed_ff <= 1'b1;
		end else if (qual_hit) begin
			armed_ff <= 1'b0;
		end else if (armed_ff) begin
			qual_ff <= qual_ff + 9'h001;
		end
		ft.sync_accept <= !rst_i && qual_hit;
	end

	// ------------------------------------------------------------
	// Interval timer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || qual_hit) begin
			running_ff <= qual_hit && !rst_i;
			last_ff    <= 1'b0;
			div_ff     <= '0;
			iv_ff      <= '0;
		end else begin
			if (ft.frame_done)
				last_ff <= 1'b1;
			if (tick) begin
				div_ff <= '0;
				iv_ff  <= (iv_ff == 4'(INTERVALS - 1)) ? 4'h0 : iv_ff + 4'h1;
				if (iv_ff == IV_SHIFT && last_ff)
					running_ff <= 1'b0;
			end else if (running_ff) begin
				div_ff <= div_ff + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Sampling and strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_ff         <= '0;
			ft.voted_bit    <= 1'b0;
			ft.shift_strobe <= 1'b0;
			ft.latch_strobe <= 1'b0;
			ft.count_strobe <= 1'b0;
			ft.clear_strobe <= 1'b0;
		end else begin
			if (tick && iv_ff >= IV_SAMP_A && iv_ff <= IV_SAMP_E)
				samp_ff <= {samp_ff[3:0], data_s}; // [R17]
			if (tick && iv_ff == IV_SHIFT)
				ft.voted_bit <= vote5(samp_ff); // [R17]
			ft.shift_strobe <= tick && iv_ff == IV_SHIFT;
			ft.latch_strobe <= tick && iv_ff == IV_LATCH;
			ft.count_strobe <= tick && iv_ff == IV_COUNT;
			ft.clear_strobe <= tick && iv_ff == IV_CLEAR;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/luminaire_frame_data_latch.sv ----
/*
 * Back end of the luminaire serial data receiver: byte assembly, address
 * gating, five byte latches, lamp controls, signal loss and Wishbone access.
 * Assumes a 40 MHz clock, synchronous reset held from power-up, and raw
 * asynchronous sync and data pins.
 */
// Function
// [R1] Shift voted bit; byte feeds compare and latches.
// [R2] Latch needs match, slot select and strobe.
// [R3] Slots in order: intensity, lamp, pan, tilt, color, beam.
// [R4] Latched bytes drive outputs continuously, no reclock; wheel outputs are registered one cycle behind the color latch.
// [R5] Color byte indexes three 3-bit wheel tables.
// [R6] Lamp-on from field 10 into history register.
// [R7] History shifts once per frame on lamp slot.
// [R8] Lamp-on follows majority of three history bits.
// [R9] Ignite from field 11 latched with effect bits.
// [R10] Ignite output is inverse of latched bit.
// [R11] Zero intensity asserts standby after half second.
// [R12] Nonzero intensity drops standby at once.
// [R13] Each sync restarts 220 ms signal timeout.
// [R14] No signal forces intensity latch to zero.
// [R15] Count returns to zero at bit 57.
// [R16] Address match holds enable for the frame.
// [R17] Bit is 3-of-5 vote of 1 us samples.
// [R18] Sync counts only after 10 us present.
// [R19] Delays are system clock counters; sync re-arms.
// [R20] Reset clears latches, history, lamp-on, signal.
`timescale 1ns/1ps
`default_nettype none
module luminaire_frame_data_latch #(
	parameter int STANDBY_CYCLES = lum_pkg::STANDBY_CYC,
	parameter int TIMEOUT_CYCLES = lum_pkg::SYNC_TIMEOUT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sync_in_i,
	input  wire logic        serial_bit_in_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic [7:0]       intensity_o,
	output logic [7:0]       pan_o,
	output logic [7:0]       tilt_o,
	output logic [7:0]       beam_o,
	output logic [2:0]       wheel0_o,
	output logic [2:0]       wheel1_o,
	output logic [2:0]       wheel2_o,
	output logic             lamp_power_on_o,
	output logic             lamp_ignite_n_o,
	output logic             lamp_standby_o,
	output logic             signal_present_o
);
	import lum_pkg::*;

	// The sampler owns both pin synchronisers; nothing here reads a raw pin.
	frame_timing_if ft ();

	bit_sampler u_sampler (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.sync_in_i       (sync_in_i),
		.serial_bit_in_i (serial_bit_in_i),
		.ft              (ft.sampler)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [5:0]  count_ff;
	logic [7:0]  byte_bus_ff;
	logic        address_match_enable_n_ff;
	logic [3:0]  lamp_bits_ff;
	logic [2:0]  lamp_ctrl_ff;
	logic [7:0]  color_ff;
	logic [2:0]  history_ff;
	logic [31:0] standby_cnt_ff;
	logic [31:0] timeout_cnt_ff;
	logic [7:0]  fixture_addr_ff;
	logic        frame_done_ff;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic       latch_ok;
	logic       slot_sel_intensity_n;
	logic       slot_sel_lamp_ctrl_n;
	logic       slot_sel_pan_n;
	logic       slot_sel_tilt_n;
	logic       slot_sel_color_n;
	logic       slot_sel_beam_n;
	logic       at_frame_end;
	logic       in_lamp_bits;
	logic [1:0] lamp_idx;
	logic       intensity_zero;
	logic       wb_req;
	logic       wb_wr;
	logic [31:0] rd_mux;

	// Slot selects are active low, like the latch enable they are gated with.
	function automatic logic slot_n(input logic [5:0] cnt, input logic [5:0] slot);
		return !(cnt == slot);
	endfunction

	function automatic logic maj3(input logic [2:0] h);
		return (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
	endfunction

	assign slot_sel_intensity_n = slot_n(count_ff, CNT_SLOT_INT);   // [R3]
	assign slot_sel_lamp_ctrl_n = slot_n(count_ff, CNT_SLOT_LAMP);  // [R3]
	assign slot_sel_pan_n       = slot_n(count_ff, CNT_SLOT_PAN);   // [R3]
	assign slot_sel_tilt_n      = slot_n(count_ff, CNT_SLOT_TILT);  // [R3]
	assign slot_sel_color_n     = slot_n(count_ff, CNT_SLOT_COLOR); // [R3]
	assign slot_sel_beam_n      = slot_n(count_ff, CNT_SLOT_BEAM);  // [R3]

	assign latch_ok       = !address_match_enable_n_ff && ft.latch_strobe; // [R2]
	assign at_frame_end   = ft.clear_strobe && count_ff == CNT_FRAME_END;
	assign in_lamp_bits   = count_ff >= CNT_LAMP_FIRST && count_ff <= CNT_LAMP_LAST;
	assign lamp_idx       = 2'(count_ff - CNT_LAMP_FIRST);
	assign intensity_zero = intensity_o == 8'h00;                     // [R11]
	assign ft.frame_done  = frame_done_ff;

	// ----------------------------------------------------------------
	// Bit counter and shift register
	// ----------------------------------------------------------------
	// A new sync restarts the count even if the last frame was cut short.
	always_ff @(posedge clk_i) begin
		if (rst_i || ft.sync_accept) begin
			count_ff <= '0;
		end else if (at_frame_end) begin
			count_ff <= '0; // [R15]
		end else if (ft.count_strobe) begin
			count_ff <= count_ff + 6'h01;
		end
		frame_done_ff <= !rst_i && at_frame_end; // [R15]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			byte_bus_ff <= '0;
		else if (ft.shift_strobe)
			byte_bus_ff <= {byte_bus_ff[6:0], ft.voted_bit}; // [R1]
	end

	// ----------------------------------------------------------------
	// Address gate and lamp bits
	// ----------------------------------------------------------------
	// The enable is cleared at each new sync so a stale match from the
	// previous frame can never open the latches.
	always_ff @(posedge clk_i) begin
		if (rst_i || ft.sync_accept)
			address_match_enable_n_ff <= 1'b1;
		else if (ft.clear_strobe && count_ff == CNT_ADDR_SAMPLE)
			address_match_enable_n_ff <= !(byte_bus_ff == fixture_addr_ff); // [R16]
	end

	// Lamp bits ride outside the byte path and are caught as they arrive.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lamp_bits_ff <= '0;
		else if (ft.shift_strobe && in_lamp_bits)
			lamp_bits_ff[lamp_idx] <= ft.voted_bit; // [R6] [R9]
	end

	// ----------------------------------------------------------------
	// Byte latches
	// ----------------------------------------------------------------
	// Loss of signal wins over a latch so the iris closes even mid-frame.
	always_ff @(posedge clk_i) begin
		if (rst_i || !signal_present_o)
			intensity_o <= '0; // [R14] [R20]
		else if (latch_ok && !slot_sel_intensity_n)
			intensity_o <= byte_bus_ff; // [R2] [R4]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pan_o        <= '0; // [R20]
			tilt_o       <= '0;
			color_ff     <= '0;
			beam_o       <= '0;
			lamp_ctrl_ff <= '0;
			history_ff   <= '0;
		end else begin
			if (latch_ok && !slot_sel_pan_n)
				pan_o <= byte_bus_ff; // [R2] [R4]
			if (latch_ok && !slot_sel_tilt_n)
				tilt_o <= byte_bus_ff; // [R4]
			if (latch_ok && !slot_sel_color_n)
				color_ff <= byte_bus_ff;
			if (latch_ok && !slot_sel_beam_n)
				beam_o <= byte_bus_ff; // [R4]
			if (latch_ok && !slot_sel_lamp_ctrl_n) begin
				lamp_ctrl_ff <= lamp_bits_ff[3:1]; // [R9]
				history_ff   <= {history_ff[1:0], lamp_bits_ff[0]}; // [R6] [R7]
			end
		end
	end

	// ----------------------------------------------------------------
	// Color wheel tables
	// ----------------------------------------------------------------
	// Table outputs are registered one cycle behind the color latch.
	// The extra cycle is harmless: the wheels move far slower than that.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wheel0_o <= '0;
			wheel1_o <= '0;
			wheel2_o <= '0;
		end else begin
			wheel0_o <= WHEEL_LUT[0][color_ff[7:5]]; // [R5]
			wheel1_o <= WHEEL_LUT[1][color_ff[7:5]]; // [R5]
			wheel2_o <= WHEEL_LUT[2][color_ff[7:5]]; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// Lamp controls
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lamp_power_on_o <= 1'b0; // [R20]
			lamp_ignite_n_o <= 1'b1;
		end else begin
			// Two of three frames decide, so one corrupt frame cannot douse it.
			lamp_power_on_o <= maj3(history_ff); // [R8]
			lamp_ignite_n_o <= !lamp_ctrl_ff[LC_IGNITE]; // [R10]
		end
	end

	// Entry waits for the iris to close; exit is immediate because the
	// iris is already opening and run current must follow it.
	always_ff @(posedge clk_i) begin
		if (rst_i || !intensity_zero) begin
			standby_cnt_ff <= '0;
			lamp_standby_o <= 1'b0; // [R12]
		end else if (standby_cnt_ff == 32'(STANDBY_CYCLES - 1)) begin
			lamp_standby_o <= 1'b1; // [R11] [R19]
		end else begin
			standby_cnt_ff <= standby_cnt_ff + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Signal sensing
	// ----------------------------------------------------------------
	// At expiry the counter parks at its end value, so the flag stays clear
	// until the next qualified sync sets it again.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_cnt_ff   <= '0;
			signal_present_o <= 1'b0; // [R20]
		end else if (ft.sync_accept) begin
			timeout_cnt_ff   <= '0; // [R13]
			signal_present_o <= 1'b1; // [R19]
		end else if (timeout_cnt_ff == 32'(TIMEOUT_CYCLES - 1)) begin
			signal_present_o <= 1'b0; // [R13]
		end else if (signal_present_o) begin
			timeout_cnt_ff <= timeout_cnt_ff + 32'h0000_0001; // [R19]
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Masking with ack keeps one held request from being taken twice.
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i;

	// Unmapped offsets read as zero; writes to them are dropped.
	assign rd_mux =
		(wb_adr_i == REG_ADDR)   ? {24'h00_0000, fixture_addr_ff} :
		(wb_adr_i == REG_STATUS) ? {20'h0_0000, count_ff[5:0] == 6'h00, history_ff,
		                            !address_match_enable_n_ff, lamp_ignite_n_o,
		                            lamp_standby_o, lamp_power_on_o,
		                            signal_present_o, lamp_ctrl_ff} :
		(wb_adr_i == REG_LATCH0) ? {tilt_o, pan_o, 5'h00, lamp_ctrl_ff, intensity_o} :
		(wb_adr_i == REG_LATCH1) ? {7'h00, wheel2_o, wheel1_o, wheel0_o,
		                            beam_o, color_ff} :
		32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o        <= 1'b0;
			wb_dat_o        <= '0;
			fixture_addr_ff <= ADDR_RESET;
		end else begin
			wb_ack_o <= wb_req;
			// Data is zero outside ack so an OR of several slaves stays clean.
			wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
			if (wb_wr && wb_adr_i == REG_ADDR && wb_sel_i[0])
				fixture_addr_ff <= wb_dat_i[7:0];
		end
	end
endmodule
`default_nettype wire

// ---- tb/lum_latch_chk.sv ----
/*
 * Port checker for the frame data latch, bound into the top module.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lum_latch_chk #(
	parameter int STANDBY_CYCLES = 200,
	parameter int TIMEOUT_CYCLES = 24200
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        sync_in_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [7:0]  intensity_o,
	input wire logic        lamp_power_on_o,
	input wire logic        lamp_standby_o,
	input wire logic        signal_present_o
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	logic [31:0] zero_cnt_ff;
	logic [31:0] quiet_cnt_ff;
	logic [31:0] high_cnt_ff;

	always_ff @(posedge clk_i) begin
		zero_cnt_ff  <= (rst_i || intensity_o != 8'h00) ? 32'h0 : zero_cnt_ff + 32'h1;
		quiet_cnt_ff <= (rst_i || sync_in_i) ? 32'h0 : quiet_cnt_ff + 32'h1;
		high_cnt_ff  <= (rst_i || !sync_in_i) ? 32'h0 : high_cnt_ff + 32'h1;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence lamp_changed;
		$changed(lamp_power_on_o);
	endsequence

	AST_ACK_NEXT: assert property (wb_req |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	AST_STBY_DROP: assert property (intensity_o != 8'h00 |-> ##[0:3] !lamp_standby_o)
		else $error("standby not dropped on nonzero intensity");
	AST_STBY_LATE: assert property (zero_cnt_ff > 32'(STANDBY_CYCLES + 4) |-> lamp_standby_o)
		else $error("standby missing after zero intensity delay");
	AST_STBY_EARLY: assert property ($rose(lamp_standby_o) |-> zero_cnt_ff + 32'd3 >= 32'(STANDBY_CYCLES))
		else $error("standby asserted too early");
	AST_SIG_LOSS: assert property (quiet_cnt_ff > 32'(TIMEOUT_CYCLES + 16) |-> !signal_present_o)
		else $error("signal present kept after timeout");
	AST_SIG_EARLY: assert property ($fell(signal_present_o) |-> quiet_cnt_ff + 32'd420 >= 32'(TIMEOUT_CYCLES))
		else $error("signal present dropped before timeout");
	AST_SIG_QUAL: assert property ($rose(signal_present_o) |-> high_cnt_ff >= 32'd390)
		else $error("signal present set by unqualified sync");
	AST_INT_LOST: assert property (!signal_present_o && !$past(signal_present_o, 2) |-> intensity_o == 8'h00)
		else $error("intensity not cleared without signal");
	AST_LAMP_STEADY: assert property (lamp_changed |=> $stable(lamp_power_on_o) [*8])
		else $error("lamp power output toggled quickly");
endmodule

bind luminaire_frame_data_latch lum_latch_chk #(
	.STANDBY_CYCLES(STANDBY_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .sync_in_i(sync_in_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.intensity_o(intensity_o), .lamp_power_on_o(lamp_power_on_o),
	.lamp_standby_o(lamp_standby_o), .signal_present_o(signal_present_o)
);
`default_nettype wire

// ---- tb/rack_model.sv ----
/*
 * Behavioural control rack: sync pulses and framed serial bit fields.
 * Assumes the bench clock; its tasks are called from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module rack_model (
	input  wire logic clk_i,
	output logic      sync_o,
	output logic      data_o
);
	// ------------------------------------------------------------
	// Senders
	// ------------------------------------------------------------
	initial begin
		sync_o = 1'b0;
		data_o = 1'b0;
	end

	task automatic short_pulse(input int len);
		sync_o <= 1'b1;
		repeat (len) @(posedge clk_i);
		sync_o <= 1'b0;
		@(posedge clk_i);
	endtask

	// The line toggles after a frame so a held level cannot hide a late sample.
	task automatic send_frame(input logic [56:0] f, input logic glitch);
		sync_o <= 1'b1;
		repeat (410) @(posedge clk_i);
		sync_o <= 1'b0;
		for (int k = 56; k >= 0; k--) begin
			data_o <= f[k];
			repeat (190) @(posedge clk_i);
			if (glitch) begin
				data_o <= ~f[k];
			end
			repeat (40) @(posedge clk_i);
			data_o <= f[k];
			repeat (170) @(posedge clk_i);
		end
		repeat (400) begin
			data_o <= ~data_o;
			@(posedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/luminaire_frame_data_latch_tb_top.sv ----
/*
 * Self-checking bench for the frame data latch: reset, registers, frames,
 * lamp history and signal loss. Assumes the rack model and bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module luminaire_frame_data_latch_tb_top;
	import lum_pkg::*;
	localparam int STBY = 200;
	localparam int TMO  = 24200;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [7:0]  intensity_o, pan_o, tilt_o, beam_o;
	logic [2:0]  wheel0_o, wheel1_o, wheel2_o;
	logic        lamp_power_on_o, lamp_ignite_n_o, lamp_standby_o, signal_present_o;
	logic        sync_line, data_line;
	int          mismatches;
	int          comparisons;

	rack_model rack_u (.clk_i(clk_i), .sync_o(sync_line), .data_o(data_line));
	luminaire_frame_data_latch #(.STANDBY_CYCLES(STBY), .TIMEOUT_CYCLES(TMO)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .sync_in_i(sync_line), .serial_bit_in_i(data_line),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.intensity_o(intensity_o), .pan_o(pan_o), .tilt_o(tilt_o), .beam_o(beam_o),
		.wheel0_o(wheel0_o), .wheel1_o(wheel1_o), .wheel2_o(wheel2_o),
		.lamp_power_on_o(lamp_power_on_o), .lamp_ignite_n_o(lamp_ignite_n_o),
		.lamp_standby_o(lamp_standby_o), .signal_present_o(signal_present_o)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
			output logic [31:0] rdat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		check(n, 32'd2);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic expect_out(input logic [31:0] bytes, input logic [2:0] ci,
			input logic [3:0] flags, input logic [5:0] stat);
		check({intensity_o, pan_o, tilt_o, beam_o}, bytes);
		check({wheel2_o, wheel1_o, wheel0_o}, {WHEEL_LUT[2][ci], WHEEL_LUT[1][ci], WHEEL_LUT[0][ci]});
		check({lamp_power_on_o, lamp_ignite_n_o, lamp_standby_o, signal_present_o}, flags);
		wb(1'b0, REG_STATUS, 32'h0, rd);
		check({rd[10:8], rd[2:0]}, stat);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check({intensity_o, pan_o, tilt_o, beam_o}, 32'h0);
		check({wheel2_o, wheel1_o, wheel0_o, lamp_power_on_o, lamp_ignite_n_o, lamp_standby_o,
			signal_present_o}, 32'h4);
		repeat (STBY - 15) @(posedge clk_i);
		check(lamp_standby_o, 1'b0);
		repeat (25) @(posedge clk_i);
		check(lamp_standby_o, 1'b1);
	endtask

	task automatic t_regs();
		wb(1'b0, REG_ADDR, 32'h0, rd);
		check(rd, {24'h0, ADDR_RESET});
		wb(1'b1, REG_ADDR, 32'hFFFF_FF5A, rd);
		wb(1'b0, REG_ADDR, 32'h0, rd);
		check(rd, 32'h5A);
		wb(1'b1, REG_LATCH0, 32'hFFFF_FFFF, rd);
		wb(1'b0, REG_LATCH0, 32'h0, rd);
		check(rd, 32'h0);
		wb(1'b0, 4'h2, 32'h0, rd);
		check(rd, 32'h0);
	endtask

	task automatic t_short();
		rack_u.short_pulse(200);
		repeat (600) @(posedge clk_i);
		check(signal_present_o, 1'b0);
	endtask

	// Glitched fields must still vote to the sent bits.
	task automatic t_frame_hit();
		rack_u.send_frame({8'h5A, 1'b1, 4'b1101, 8'hC3, 8'h81, 8'h7E, 8'hA0, 8'h3C, 4'hF}, 1'b1);
		expect_out(32'hC3817E3C, 3'd5, 4'b0001, 6'b001101);
		wb(1'b0, REG_LATCH1, 32'h0, rd);
		check(rd, {7'h0, WHEEL_LUT[2][5], WHEEL_LUT[1][5], WHEEL_LUT[0][5], 8'h3C, 8'hA0});
	endtask

	task automatic t_frame_miss();
		rack_u.send_frame({8'h33, 1'b1, 4'b1111, 8'h11, 8'h22, 8'h33, 8'hE0, 8'h55, 4'hF}, 1'b0);
		expect_out(32'hC3817E3C, 3'd5, 4'b0001, 6'b001101);
	endtask

	task automatic t_frame_lamp();
		rack_u.send_frame({8'h5A, 1'b1, 4'b1000, 8'h44, 8'h90, 8'h09, 8'h20, 8'hF0, 4'hF}, 1'b0);
		expect_out(32'h449009F0, 3'd1, 4'b1101, 6'b011000);
	endtask

	task automatic t_loss();
		int n;
		n = 0;
		while (signal_present_o !== 1'b0 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (3) @(posedge clk_i);
		check({signal_present_o, intensity_o, pan_o}, {1'b0, 8'h00, 8'h90});
		repeat (STBY + 10) @(posedge clk_i);
		check(lamp_standby_o, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Clock, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_regs();
		t_short();
		t_frame_hit();
		t_frame_miss();
		t_frame_lamp();
		t_loss();
		report_and_stop();
	end

	// The full run is about 73000 cycles; this leaves a wide margin.
	initial begin
		repeat (100000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
